// *** src/lpc_pkg.sv ***
// Purpose: Shared constants for the laser power feed-forward / feedback core
// Assumes: 200 MHz system clock
// Notes:   Times are kept in their own units, cycle counts derive from them
`default_nettype none
package lpc_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int TEMP_PERIOD_MS = 64;
    localparam int TEMP_PERIOD_CYC = CLK_HZ / 1000 * TEMP_PERIOD_MS;
    localparam int CMP_RATE_HZ = 512_000;
    localparam int CMP_PERIOD_CYC = CLK_HZ / CMP_RATE_HZ;
    localparam int DATA_W = 8;
    localparam int MAIN_TBL_DEPTH = 128;
    localparam int AUX_TBL_DEPTH = 32;
    localparam int GAIN_W = 6;
    localparam int TARGET_W = 5;
    localparam int RATIO_W = 7;
    localparam int FB_W = 8;
    localparam int MAIN_SHIFT = 1;
    localparam int AUX_SHIFT = 3;
    localparam int RATIO_SHIFT = 7;
    localparam logic [FB_W-1:0] FB_RESET = 8'h00;
    localparam logic [1:0] FF_SEL_RESET = 2'h3;
    localparam logic [1:0] FB_SEL_RESET = 2'h0;
    localparam logic [1:0] FB_OFF = 2'h0;
    localparam logic [1:0] FB_MOD_ONLY = 2'h1;
    localparam logic [1:0] FB_BIAS_ONLY = 2'h2;
    localparam logic [1:0] FB_SPLIT = 2'h3;
    localparam int SEL_BIAS_BIT = 1;
    localparam int SEL_MOD_BIT = 0;
endpackage
`default_nettype wire

// *** src/lpc_interp.sv ***
// Purpose: Signed linear interpolation between two table neighbours
// Assumes: Fraction below 2**SHIFT
// Notes:   Result lies between the neighbours, so it fits the data width
`timescale 1ns/1ps
`default_nettype none
module lpc_interp #(
    parameter int DW = 8,
    parameter int SHIFT = 1
) (
    input wire logic [DW-1:0] lo_val,
    input wire logic [DW-1:0] hi_val,
    input wire logic [SHIFT-1:0] frac,
    output logic [DW-1:0] result
);
    logic signed [DW+SHIFT+1:0] diff;
    logic signed [DW+SHIFT+1:0] sum;

    // Signed slope keeps falling tables falling
    always_comb
    begin
        diff = ($signed({{(SHIFT+2){1'b0}}, hi_val}) - $signed({{(SHIFT+2){1'b0}}, lo_val}))
            * $signed({{(DW+2){1'b0}}, frac});
        sum = ($signed({2'b00, lo_val, {SHIFT{1'b0}}}) + diff) >>> SHIFT;
        result = sum[DW-1:0];
    end
endmodule
`default_nettype wire

// *** src/lpc_core.sv ***
// Purpose: Digital core of an automatic laser optical power controller
// Assumes: Analog sensor ADC, comparator and DACs sit outside; pins are synchronous
// Notes:   Tables are written over classic Wishbone; the loop runs by itself
//
// Added by the designer: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module lpc_core #(
    parameter int TEMP_PERIOD = lpc_pkg::TEMP_PERIOD_CYC,
    parameter int CMP_PERIOD = lpc_pkg::CMP_PERIOD_CYC
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic WB_ACK_O,
    output logic ADC_START,
    input wire logic ADC_DONE,
    input wire logic [7:0] ADC_CODE,
    output logic CMP_SAMPLE,
    input wire logic CMP_MONITOR_LOW,
    output logic [5:0] MONITOR_GAIN_CODE,
    output logic [4:0] TARGET_DAC_CODE,
    output logic [7:0] BIAS_DAC_CODE,
    output logic [7:0] CURRENT_DAC_CODE,
    output logic [7:0] VOLTAGE_DAC_CODE
);
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_RATIO = 12'h004;
    localparam logic [11:0] A_STATUS = 12'h008;
    localparam logic [11:0] A_BIAS_T = 12'h200;
    localparam logic [11:0] A_MOD_T = 12'h400;
    localparam logic [11:0] A_AUX_T = 12'h600;
    localparam int DW = lpc_pkg::DATA_W;

    logic [DW-1:0] bias_temperature_table [lpc_pkg::MAIN_TBL_DEPTH];
    logic [DW-1:0] modulation_temperature_table [lpc_pkg::MAIN_TBL_DEPTH];
    logic [DW-1:0] auxiliary_temperature_table [lpc_pkg::AUX_TBL_DEPTH];

    logic [5:0] monitor_gain_code_reg, monitor_gain_code_next;
    logic [4:0] power_target_code_reg, power_target_code_next;
    logic dac_route_select_reg, dac_route_select_next;
    logic [1:0] feedforward_path_select_reg, feedforward_path_select_next;
    logic [1:0] feedback_path_select_reg, feedback_path_select_next;
    logic [6:0] bias_feedback_ratio_reg, bias_feedback_ratio_next;
    logic [6:0] modulation_feedback_ratio_reg, modulation_feedback_ratio_next;
    logic ack_reg, ack_next;
    logic [31:0] rdata_reg, rdata_next;

    // ------------------------------------------------------------
    // Wishbone slave: one wait state, ack drops after one cycle
    // ------------------------------------------------------------
    logic bus_req;
    logic wr_en;
    logic [11:0] adr;
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_reg;
    assign wr_en = bus_req && WB_WE_I && WB_SEL_I[0];
    assign adr = {WB_ADR_I[11:2], 2'b00};

    // Table writes; only byte lane zero carries data
    always_ff @(posedge CLK)
    begin
        if (wr_en && adr[11:9] == A_BIAS_T[11:9])
            bias_temperature_table[adr[8:2]] <= WB_DAT_I[7:0];
        if (wr_en && adr[11:9] == A_MOD_T[11:9])
            modulation_temperature_table[adr[8:2]] <= WB_DAT_I[7:0];
        if (wr_en && adr[11:9] == A_AUX_T[11:9] && adr[8:7] == 2'b00)
            auxiliary_temperature_table[adr[6:2]] <= WB_DAT_I[7:0];
    end

    localparam int FB_W_L = lpc_pkg::FB_W;
    logic [7:0] temp_code_reg, temp_code_next;
    logic [FB_W_L-1:0] feedback_current_code_reg;

    // Control register next values and read data
    always_comb
    begin
        monitor_gain_code_next = monitor_gain_code_reg;
        power_target_code_next = power_target_code_reg;
        dac_route_select_next = dac_route_select_reg;
        feedforward_path_select_next = feedforward_path_select_reg;
        feedback_path_select_next = feedback_path_select_reg;
        bias_feedback_ratio_next = bias_feedback_ratio_reg;
        modulation_feedback_ratio_next = modulation_feedback_ratio_reg;
        ack_next = bus_req;
        rdata_next = 32'h0000_0000;
        if (wr_en && adr == A_CTRL)
        begin
            monitor_gain_code_next = WB_DAT_I[5:0];
            power_target_code_next = WB_DAT_I[12:8];
            dac_route_select_next = WB_DAT_I[16];
            feedforward_path_select_next = WB_DAT_I[25:24];
            feedback_path_select_next = WB_DAT_I[29:28];
        end
        if (wr_en && adr == A_RATIO)
        begin
            bias_feedback_ratio_next = WB_DAT_I[6:0];
            modulation_feedback_ratio_next = WB_DAT_I[14:8];
        end
        case (adr[11:9])
            A_CTRL[11:9]:
            begin
                if (adr == A_CTRL)
                    rdata_next = {2'b00, feedback_path_select_reg, 2'b00,
                        feedforward_path_select_reg, 7'h00, dac_route_select_reg, 3'h0,
                        power_target_code_reg, 2'b00, monitor_gain_code_reg};
                else if (adr == A_RATIO)
                    rdata_next = {17'h00000, modulation_feedback_ratio_reg, 1'b0,
                        bias_feedback_ratio_reg};
                else if (adr == A_STATUS)
                    rdata_next = {16'h0000, feedback_current_code_reg, temp_code_reg};
            end
            A_BIAS_T[11:9]: rdata_next = {24'h000000, bias_temperature_table[adr[8:2]]};
            A_MOD_T[11:9]: rdata_next = {24'h000000, modulation_temperature_table[adr[8:2]]};
            A_AUX_T[11:9]:
            begin
                if (adr[8:7] == 2'b00)
                    rdata_next = {24'h000000, auxiliary_temperature_table[adr[6:2]]};
            end
            default: rdata_next = 32'h0000_0000;
        endcase
        if (!bus_req || WB_WE_I)
            rdata_next = 32'h0000_0000;
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            monitor_gain_code_reg <= 6'h00;
            power_target_code_reg <= 5'h00;
            dac_route_select_reg <= 1'b0;
            feedforward_path_select_reg <= lpc_pkg::FF_SEL_RESET;
            feedback_path_select_reg <= lpc_pkg::FB_SEL_RESET;
            bias_feedback_ratio_reg <= 7'h00;
            modulation_feedback_ratio_reg <= 7'h00;
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            monitor_gain_code_reg <= monitor_gain_code_next;
            power_target_code_reg <= power_target_code_next;
            dac_route_select_reg <= dac_route_select_next;
            feedforward_path_select_reg <= feedforward_path_select_next;
            feedback_path_select_reg <= feedback_path_select_next;
            bias_feedback_ratio_reg <= bias_feedback_ratio_next;
            modulation_feedback_ratio_reg <= modulation_feedback_ratio_next;
            ack_reg <= ack_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Temperature detection sequencer, free running
    // ------------------------------------------------------------
    typedef enum logic [1:0] {T_WAIT, T_CONV, T_LOOKUP, T_LOAD} lpc_tstate_e;
    lpc_tstate_e tstate_reg, tstate_next;
    logic [31:0] tcnt_reg, tcnt_next;
    logic adc_start_reg, adc_start_next;

    // Period counter restarts each 64 ms frame regardless of conversion length
    always_comb
    begin
        tstate_next = tstate_reg;
        temp_code_next = temp_code_reg;
        adc_start_next = 1'b0;
        tcnt_next = (tcnt_reg == 32'(TEMP_PERIOD - 1)) ? 32'h0000_0000 : tcnt_reg + 32'h1;
        case (tstate_reg)
            T_WAIT:
            begin
                if (tcnt_reg == 32'h0000_0000)
                begin
                    adc_start_next = 1'b1;
                    tstate_next = T_CONV;
                end
            end
            T_CONV:
            begin
                if (ADC_DONE)
                begin
                    temp_code_next = ADC_CODE;
                    tstate_next = T_LOOKUP;
                end
            end
            T_LOOKUP: tstate_next = T_LOAD;
            T_LOAD: tstate_next = T_WAIT;
            default: tstate_next = T_WAIT;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            tstate_reg <= T_WAIT;
            tcnt_reg <= 32'h0000_0000;
            temp_code_reg <= 8'h00;
            adc_start_reg <= 1'b0;
        end
        else
        begin
            tstate_reg <= tstate_next;
            tcnt_reg <= tcnt_next;
            temp_code_reg <= temp_code_next;
            adc_start_reg <= adc_start_next;
        end
    end
    assign ADC_START = adc_start_reg;

    // ------------------------------------------------------------
    // Table lookup and interpolation
    // ------------------------------------------------------------
    logic [6:0] mx, mx_lo;
    logic [4:0] ay, ay_lo;
    logic [DW-1:0] bias_hi, bias_lo, mod_hi, mod_lo, aux_hi, aux_lo;
    logic [DW-1:0] bias_feedforward_value, modulation_feedforward_value;
    logic [DW-1:0] auxiliary_interp_value;

    // Index below zero clamps to entry zero
    always_comb
    begin
        mx = temp_code_reg[7:1];
        mx_lo = (mx == 7'h00) ? 7'h00 : mx - 7'h01;
        ay = temp_code_reg[7:3];
        ay_lo = (ay == 5'h00) ? 5'h00 : ay - 5'h01;
    end

    // Tables read as registered RAM so they map onto block memory
    always_ff @(posedge CLK)
    begin
        bias_hi <= bias_temperature_table[mx];
        bias_lo <= bias_temperature_table[mx_lo];
        mod_hi <= modulation_temperature_table[mx];
        mod_lo <= modulation_temperature_table[mx_lo];
        aux_hi <= auxiliary_temperature_table[ay];
        aux_lo <= auxiliary_temperature_table[ay_lo];
    end

    lpc_interp #(.DW(DW), .SHIFT(lpc_pkg::MAIN_SHIFT)) u_bias (
        .lo_val(bias_lo), .hi_val(bias_hi), .frac(temp_code_reg[0:0]),
        .result(bias_feedforward_value));
    lpc_interp #(.DW(DW), .SHIFT(lpc_pkg::MAIN_SHIFT)) u_mod (
        .lo_val(mod_lo), .hi_val(mod_hi), .frac(temp_code_reg[0:0]),
        .result(modulation_feedforward_value));
    lpc_interp #(.DW(DW), .SHIFT(lpc_pkg::AUX_SHIFT)) u_aux (
        .lo_val(aux_lo), .hi_val(aux_hi), .frac(temp_code_reg[2:0]),
        .result(auxiliary_interp_value));

    // ------------------------------------------------------------
    // Feedback loop: comparator pacing and up/down filter
    // ------------------------------------------------------------
    logic [15:0] ccnt_reg, ccnt_next;
    logic cmp_tick;
    logic [FB_W_L-1:0] fb_next;
    assign cmp_tick = (ccnt_reg == 16'(CMP_PERIOD - 1));

    // Saturating counter is the simplest filter that converges
    always_comb
    begin
        ccnt_next = cmp_tick ? 16'h0000 : ccnt_reg + 16'h0001;
        fb_next = feedback_current_code_reg;
        if (cmp_tick)
        begin
            if (CMP_MONITOR_LOW)
                fb_next = (&feedback_current_code_reg) ? feedback_current_code_reg
                    : feedback_current_code_reg + 8'h01;
            else
                fb_next = (feedback_current_code_reg == 8'h00) ? 8'h00
                    : feedback_current_code_reg - 8'h01;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            ccnt_reg <= 16'h0000;
            feedback_current_code_reg <= lpc_pkg::FB_RESET;
        end
        else
        begin
            ccnt_reg <= ccnt_next;
            feedback_current_code_reg <= fb_next;
        end
    end
    assign CMP_SAMPLE = cmp_tick;

    // ------------------------------------------------------------
    // Output combination and DAC loading
    // ------------------------------------------------------------
    logic [DW-1:0] bias_fb, mod_fb, bias_ff, mod_ff, bias_sum, mod_sum;
    logic [14:0] bias_prod, mod_prod;
    logic [7:0] bias_dac_reg, cur_dac_reg, volt_dac_reg;
    logic [8:0] bias_wide, mod_wide;

    // Feedback share per path; sums clip at full scale
    always_comb
    begin
        bias_prod = feedback_current_code_reg * bias_feedback_ratio_reg;
        mod_prod = feedback_current_code_reg * modulation_feedback_ratio_reg;
        case (feedback_path_select_reg)
            lpc_pkg::FB_OFF: {bias_fb, mod_fb} = {8'h00, 8'h00};
            lpc_pkg::FB_MOD_ONLY: {bias_fb, mod_fb} = {8'h00, feedback_current_code_reg};
            lpc_pkg::FB_BIAS_ONLY: {bias_fb, mod_fb} = {feedback_current_code_reg, 8'h00};
            default: {bias_fb, mod_fb} = {bias_prod[14:lpc_pkg::RATIO_SHIFT],
                mod_prod[14:lpc_pkg::RATIO_SHIFT]};
        endcase
        bias_ff = feedforward_path_select_reg[lpc_pkg::SEL_BIAS_BIT]
            ? bias_feedforward_value : 8'h00;
        mod_ff = feedforward_path_select_reg[lpc_pkg::SEL_MOD_BIT]
            ? modulation_feedforward_value : 8'h00;
        bias_wide = {1'b0, bias_ff} + {1'b0, bias_fb};
        mod_wide = {1'b0, mod_ff} + {1'b0, mod_fb};
        bias_sum = bias_wide[8] ? 8'hFF : bias_wide[7:0];
        mod_sum = mod_wide[8] ? 8'hFF : mod_wide[7:0];
    end

    // Feed-forward and feedback parts both reload together, at T_LOAD of each frame and on every comparison tick
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            bias_dac_reg <= 8'h00;
            cur_dac_reg <= 8'h00;
            volt_dac_reg <= 8'h00;
        end
        else if (tstate_reg == T_LOAD || cmp_tick)
        begin
            bias_dac_reg <= bias_sum;
            cur_dac_reg <= dac_route_select_reg ? auxiliary_interp_value : mod_sum;
            volt_dac_reg <= dac_route_select_reg ? mod_sum : auxiliary_interp_value;
        end
    end

    assign BIAS_DAC_CODE = bias_dac_reg;
    assign CURRENT_DAC_CODE = cur_dac_reg;
    assign VOLTAGE_DAC_CODE = volt_dac_reg;
    assign MONITOR_GAIN_CODE = monitor_gain_code_reg;
    assign TARGET_DAC_CODE = power_target_code_reg;
    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = rdata_reg;
endmodule
`default_nettype wire

// *** dv/lpc_front_model.sv ***
// Purpose: Model of the sensor converter and power comparator beside the core
// Assumes: Conversion ends four cycles after a start pulse
// Notes:   Code lines wander outside the done cycle so a stale read shows up
`timescale 1ns/1ps
`default_nettype none
module lpc_front_model (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic ADC_START,
    output logic ADC_DONE,
    output logic [7:0] ADC_CODE,
    output logic CMP_MONITOR_LOW,
    input wire logic [7:0] BIAS_DAC_CODE,
    input wire logic [4:0] TARGET_DAC_CODE,
    input wire logic [7:0] temp_code,
    input wire logic loop_mode,
    input wire logic [7:0] fixed_level
);
    logic [2:0] busy_cnt;
    logic [7:0] scaled_mon;
    logic [7:0] target_level;
    // Conversion: code valid only in the done cycle
    always_ff @(posedge CLK)
    begin
        ADC_DONE <= 1'b0;
        ADC_CODE <= ADC_CODE + 8'h35;
        if (RESET)
        begin
            busy_cnt <= 3'h0;
            ADC_CODE <= 8'h00;
        end
        else if (ADC_START)
            busy_cnt <= 3'h4;
        else if (busy_cnt != 3'h0)
        begin
            busy_cnt <= busy_cnt - 3'h1;
            if (busy_cnt == 3'h1)
            begin
                ADC_DONE <= 1'b1;
                ADC_CODE <= temp_code;
            end
        end
    end
    // Loop mode closes the path through the bias output, unity monitor gain
    assign scaled_mon = loop_mode ? BIAS_DAC_CODE : fixed_level;
    assign target_level = {TARGET_DAC_CODE, 3'h0};
    assign CMP_MONITOR_LOW = scaled_mon < target_level;
endmodule
`default_nettype wire

// *** dv/lpc_core_monitor.sv ***
// Purpose: Port checker for the laser power core
// Assumes: Synchronous active-high reset
// Notes:   Rates use gap counters, since long repetitions slow the tools
`timescale 1ns/1ps
`default_nettype none
module lpc_core_monitor #(
    parameter int TEMP_PERIOD = 200,
    parameter int CMP_PERIOD = 8
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [31:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic ADC_START,
    input wire logic CMP_SAMPLE,
    input wire logic [5:0] MONITOR_GAIN_CODE,
    input wire logic [4:0] TARGET_DAC_CODE
);
    // Gap counters; seen flags skip the first pulse after reset
    logic [31:0] tgap_reg, tgap_next, cgap_reg, cgap_next;
    logic tseen_reg, tseen_next, cseen_reg, cseen_next;
    always_comb
    begin
        tgap_next = ADC_START ? 32'h0 : tgap_reg + 32'h1;
        cgap_next = CMP_SAMPLE ? 32'h0 : cgap_reg + 32'h1;
        tseen_next = tseen_reg | ADC_START;
        cseen_next = cseen_reg | CMP_SAMPLE;
    end
    always_ff @(posedge CLK)
    begin
        tgap_reg <= RESET ? 32'h0 : tgap_next;
        cgap_reg <= RESET ? 32'h0 : cgap_next;
        tseen_reg <= RESET ? 1'b0 : tseen_next;
        cseen_reg <= RESET ? 1'b0 : cseen_next;
    end
    default clocking mon_cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held past one cycle");
    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not answered after one wait state");
    read_idle_a: assert property (!(WB_ACK_O && !WB_WE_I) |-> WB_DAT_O == 32'h0)
        else $error("read data not zero outside a read answer");
    start_pulse_a: assert property (ADC_START |=> !ADC_START [*2])
        else $error("conversion start longer than one cycle");
    temp_rate_a: assert property (tseen_reg |-> ADC_START == (tgap_reg == TEMP_PERIOD - 1))
        else $error("conversion start off its period");
    cmp_rate_a: assert property (cseen_reg |-> CMP_SAMPLE == (cgap_reg == CMP_PERIOD - 1))
        else $error("comparison tick off its period");
    gain_write_a: assert property (MONITOR_GAIN_CODE != $past(MONITOR_GAIN_CODE)
        |-> WB_ACK_O && WB_WE_I && WB_SEL_I[0])
        else $error("gain code moved without a bus write");
    ctrl_follow_a: assert property (WB_ACK_O && WB_WE_I && WB_SEL_I[0]
        && WB_ADR_I[11:2] == 10'h000
        |-> MONITOR_GAIN_CODE == WB_DAT_I[5:0] && TARGET_DAC_CODE == WB_DAT_I[12:8])
        else $error("control write not reflected on gain or target");
endmodule
`default_nettype wire

// *** dv/tb_lpc_core.sv ***
// Purpose: Self-checking bench for the laser power core
// Assumes: Short frame and tick periods set by parameter
// Notes:   Tables hold linear slopes so expected codes follow by hand
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_lpc_core;
    localparam int TEMP_P = 200;
    localparam int CMP_P = 8;
    typedef struct packed {logic [7:0] temp; logic route; logic [7:0] bias, cur, volt;} lpc_row_s;
    lpc_row_s rows [7] = '{'{8'h00, 1'b0, 8'h00, 8'hFF, 8'h00}, '{8'h01, 1'b1, 8'h00, 8'h00, 8'hFF},
        '{8'h03, 1'b0, 8'h01, 8'hFE, 8'h00}, '{8'h0F, 1'b0, 8'h0D, 8'hF2, 8'h07},
        '{8'h10, 1'b1, 8'h0E, 8'h08, 8'hF1}, '{8'h80, 1'b0, 8'h7E, 8'h81, 8'h78},
        '{8'hFF, 1'b0, 8'hFD, 8'h02, 8'hF7}};
    logic [7:0] exb [4] = '{8'h00, 8'h00, 8'hFF, 8'h7F};
    logic [7:0] exc [4] = '{8'h00, 8'hFF, 8'h00, 8'hFD};
    logic clk = 1'b0, reset = 1'b1, wb_we = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, loop_mode = 1'b0;
    logic [31:0] wb_adr = 32'h0, wb_dat = 32'h0, rd, wb_rdat;
    logic [3:0] wb_sel = 4'h0;
    logic [7:0] temp_code = 8'h00, fixed_level = 8'h80, adc_code, bias_code, cur_code, volt_code;
    logic [5:0] gain_code;
    logic [4:0] tgt_code;
    logic wb_ack, adc_start, adc_done, cmp_sample, mon_low;
    int miscompares = 0, check_count = 0, cycles = 0;
    lpc_core #(.TEMP_PERIOD(TEMP_P), .CMP_PERIOD(CMP_P)) i_lpc_core (.CLK(clk), .RESET(reset),
        .WB_ADR_I(wb_adr), .WB_DAT_I(wb_dat), .WB_DAT_O(wb_rdat), .WB_SEL_I(wb_sel),
        .WB_WE_I(wb_we), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_ACK_O(wb_ack),
        .ADC_START(adc_start), .ADC_DONE(adc_done), .ADC_CODE(adc_code), .CMP_SAMPLE(cmp_sample),
        .CMP_MONITOR_LOW(mon_low), .MONITOR_GAIN_CODE(gain_code), .TARGET_DAC_CODE(tgt_code),
        .BIAS_DAC_CODE(bias_code), .CURRENT_DAC_CODE(cur_code), .VOLTAGE_DAC_CODE(volt_code));
    lpc_front_model i_lpc_front_model (.CLK(clk), .RESET(reset), .ADC_START(adc_start),
        .ADC_DONE(adc_done), .ADC_CODE(adc_code), .CMP_MONITOR_LOW(mon_low),
        .BIAS_DAC_CODE(bias_code), .TARGET_DAC_CODE(tgt_code), .temp_code(temp_code),
        .loop_mode(loop_mode), .fixed_level(fixed_level));
    // ----------------------------------------
    // Bus and sequencing tasks
    // ----------------------------------------
    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Classic cycle: hold everything until ack is sampled, then release
    task automatic wb(input logic [31:0] a, input logic [31:0] d, input logic w,
        input logic [3:0] s);
        @(posedge clk);
        wb_adr <= a;
        wb_dat <= d;
        wb_we <= w;
        wb_sel <= s;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        do @(posedge clk); while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic set_ctrl(input logic [5:0] g, input logic [4:0] t, input logic r,
        input logic [1:0] ff, input logic [1:0] fb);
        wb(32'h000, {2'h0, fb, 2'h0, ff, 7'h0, r, 3'h0, t, 2'h0, g}, 1'b1, 4'hF);
    endtask
    // Next start, its done, then the lookup and load latency
    task automatic frame;
        @(posedge adc_start);
        @(posedge adc_done);
        repeat (5) @(posedge clk);
    endtask
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // Hang guard well above the expected run of about 10k cycles
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        wb(32'h000, 32'h0, 1'b0, 4'hF);
        `CHK(rd, 32'h0300_0000)
        wb(32'h00C, 32'h0000_00A5, 1'b1, 4'hF);
        wb(32'h00C, 32'h0, 1'b0, 4'hF);
        `CHK(rd, 32'h0)
        for (int i = 0; i < 128; i++)
        begin
            wb(32'h200 + 32'(4 * i), 32'(2 * i), 1'b1, 4'h1);
            wb(32'h400 + 32'(4 * i), 32'(255 - 2 * i), 1'b1, 4'h1);
            if (i < 32)
                wb(32'h600 + 32'(4 * i), 32'(8 * i), 1'b1, 4'h1);
        end
        foreach (rows[i])
        begin
            temp_code <= rows[i].temp;
            set_ctrl(6'h00, 5'h10, rows[i].route, 2'h3, 2'h0);
            frame();
            `CHK(bias_code, rows[i].bias)
            `CHK(cur_code, rows[i].cur)
            `CHK(volt_code, rows[i].volt)
            wb(32'h008, 32'h0, 1'b0, 4'hF);
            `CHK(rd[7:0], rows[i].temp)
        end
        // Awkward cases: refused lane, saturation both ways, ratio split, closed loop
        set_ctrl(6'h3F, 5'h10, 1'b0, 2'h1, 2'h2);
        `CHK(gain_code, 6'h3F)
        `CHK(tgt_code, 5'h10)
        wb(32'h000, 32'h0, 1'b1, 4'hE);
        `CHK(gain_code, 6'h3F)
        repeat (300 * CMP_P) @(posedge clk);
        wb(32'h008, 32'h0, 1'b0, 4'hF);
        `CHK(rd[15:8], 8'h00)
        fixed_level <= 8'h7F;
        repeat (300 * CMP_P) @(posedge clk);
        wb(32'h008, 32'h0, 1'b0, 4'hF);
        `CHK(rd[15:8], 8'hFF)
        `CHK(bias_code, 8'hFF)
        `CHK(cur_code, 8'h02)
        wb(32'h004, {17'h0, 7'd127, 1'b0, 7'd64}, 1'b1, 4'hF);
        for (int f = 0; f < 4; f++)
        begin
            set_ctrl(6'h00, 5'h10, 1'b0, 2'h0, 2'(f));
            repeat (3 * CMP_P) @(posedge clk);
            `CHK(bias_code, exb[f])
            `CHK(cur_code, exc[f])
        end
        loop_mode <= 1'b1;
        set_ctrl(6'h2A, 5'h10, 1'b0, 2'h1, 2'h2);
        repeat (400 * CMP_P) @(posedge clk);
        wb(32'h008, 32'h0, 1'b0, 4'hF);
        `CHK(rd[15:8] inside {[8'h7D:8'h82]}, 1'b1)
        reset <= 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        wb(32'h000, 32'h0, 1'b0, 4'hF);
        `CHK(rd, 32'h0300_0000)
        `CHK(gain_code, 6'h00)
        give_verdict();
    end
endmodule
bind lpc_core lpc_core_monitor #(.TEMP_PERIOD(TEMP_PERIOD), .CMP_PERIOD(CMP_PERIOD))
    i_lpc_core_monitor (.CLK(CLK), .RESET(RESET), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_ACK_O(WB_ACK_O), .ADC_START(ADC_START), .CMP_SAMPLE(CMP_SAMPLE),
    .MONITOR_GAIN_CODE(MONITOR_GAIN_CODE), .TARGET_DAC_CODE(TARGET_DAC_CODE));
`default_nettype wire
